// File: sos_exec_pkg.sv
// Constants and types shared by the set-all-ones and sleep executor
package sos_exec_pkg;
    localparam int APB_AW = 8;
    localparam int APB_DW = 32;
    localparam logic [7:0] ADDR_INSTR = 8'h00;
    localparam logic [7:0] ADDR_BANK = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_WDT = 8'h0C;
    localparam logic [7:0] ADDR_MEM_ADDR = 8'h10;
    localparam logic [7:0] ADDR_MEM_DATA = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;
    localparam logic [15:0] OP_SLEEP = 16'h0003;
    localparam logic [6:0] OP_SET_ONES_HI = 7'h34;
    localparam int OP_ACC_BIT = 8;
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic TIMEOUT_RST = 1'b1;
    localparam logic PDOWN_RST = 1'b1;
    localparam int IRQ_W = 4;
    localparam int IRQ_SET_ONES = 0;
    localparam int IRQ_SLEEP = 1;
    localparam int IRQ_WDT_WAKE = 2;
    localparam int IRQ_PIN_WAKE = 3;
    localparam int ST_TIMEOUT = 0;
    localparam int ST_PDOWN = 1;
    localparam int ST_ASLEEP = 2;
    localparam int ST_BUSY = 3;

    typedef enum logic [1:0] {
        Q1 = 2'b00,
        Q2 = 2'b01,
        Q3 = 2'b11,
        Q4 = 2'b10
    } quarter_t;

    typedef struct packed {
        logic set_ones;
        logic sleep;
        logic acc_sel;
        logic [7:0] faddr;
    } instr_dec_t;

    typedef struct packed {
        logic timeout_flag;
        logic power_down_flag;
    } flags_t;

    function automatic instr_dec_t decode_instr(input logic [15:0] op);
        instr_dec_t d;
        d.set_ones = (op[15:9] == OP_SET_ONES_HI);
        d.sleep = (op == OP_SLEEP);
        d.acc_sel = op[OP_ACC_BIT];
        d.faddr = op[7:0];
        return d;
    endfunction : decode_instr
endpackage : sos_exec_pkg

// File: sos_data_mem.sv
// Banked data memory with one write port and a registered read port
`timescale 1ns/10ps
module sos_data_mem #(
    parameter int AW = 12,
    parameter int DW = 8
) (
    input wire logic i_clk, // Core clock
    input wire logic i_ce, // Clock enable
    input wire logic i_we, // Write strobe
    input wire logic [AW-1:0] i_waddr, // Write address
    input wire logic [DW-1:0] i_wdata, // Write data
    input wire logic [AW-1:0] i_raddr, // Read address
    output logic [DW-1:0] o_rdata // Registered read data
);
    logic [DW-1:0] mem_r [0:(1<<AW)-1];

    // Write-through keeps a read of the just-written byte current
    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            if (i_we) begin
                mem_r[i_waddr] <= i_wdata;
            end
            if (i_we && (i_waddr == i_raddr)) begin
                o_rdata <= i_wdata;
            end else begin
                o_rdata <= mem_r[i_raddr];
            end
        end
    end
endmodule : sos_data_mem

// File: sos_executor.sv
// Executor for the set-all-ones and sleep instructions with APB registers
// Overview of operation
// - Set-all-ones takes an 8-bit register address 0..255 and a one-bit bank access selector.
// - Selector 0 addresses the fixed access bank, selector 1 uses the bank select register.
// - Sleep clears the power-down flag.
// - Sleep sets the timeout flag.
// - Sleep clears the watchdog counter and its postscaler.
// - After sleep the core is in its low-power state with the oscillator halted.
// - In sleep, quarter two does nothing, quarter three processes data, quarter four goes to sleep.
// - A watchdog timeout that wakes the core clears the timeout flag.
`timescale 1ns/10ps
module sos_executor
    import sos_exec_pkg::*;
#(
    parameter int BANK_BITS = 4,
    parameter int WDT_POST_BITS = 7,
    parameter logic [3:0] ACCESS_BANK = 4'h0
) (
    input wire logic I_CLK, // 20 MHz core clock
    input wire logic I_RST, // Synchronous reset, high
    input wire logic I_CE, // Clock enable
    input wire logic I_PSEL, // APB select
    input wire logic I_PENABLE, // APB enable
    input wire logic I_PWRITE, // APB direction
    input wire logic [APB_AW-1:0] I_PADDR, // APB byte address
    input wire logic [APB_DW-1:0] I_PWDATA, // APB write data
    output logic [APB_DW-1:0] O_PRDATA, // APB read data
    output logic O_PREADY, // APB ready
    output logic O_PSLVERR, // APB error
    input wire logic I_WDT_TICK, // Watchdog oscillator, async
    input wire logic I_WAKE, // Wake request pin, async
    output logic O_IRQ, // Interrupt level
    output logic O_SLEEP, // Core asleep
    output logic O_OSC_RUN, // Oscillator enable
    output logic O_TIMEOUT_FLAG, // Timeout flag
    output logic O_POWER_DOWN_FLAG // Power-down flag
);
    localparam int MAW = BANK_BITS + 8;

    quarter_t q_r, q_nxt;
    logic busy_r, busy_nxt;
    instr_dec_t ir_r, ir_nxt;
    logic pend_r, pend_nxt;
    logic [15:0] pend_op_r, pend_op_nxt;
    logic asleep_r, asleep_nxt;
    flags_t flags_r, flags_nxt;
    logic [7:0] wdt_cnt_r, wdt_cnt_nxt;
    logic [WDT_POST_BITS-1:0] wdt_post_r, wdt_post_nxt;
    logic [BANK_BITS-1:0] bank_r, bank_nxt;
    logic [MAW-1:0] mem_addr_r, mem_addr_nxt;
    logic [IRQ_W-1:0] irq_stat_r, irq_stat_nxt;
    logic [IRQ_W-1:0] irq_mask_r, irq_mask_nxt;
    logic [APB_DW-1:0] prdata_r, prdata_nxt;
    logic tick_s1_r, tick_s2_r, tick_s3_r;
    logic wake_s1_r, wake_s2_r;

    logic tick_rise;
    logic wdt_to;
    logic sleep_q3;
    logic exec_we;
    logic [MAW-1:0] exec_addr;
    logic [BANK_BITS-1:0] exec_bank;
    logic sw_mem_we;
    logic mem_we;
    logic [MAW-1:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    logic [IRQ_W-1:0] irq_ev;
    logic apb_access;
    logic apb_fire;
    logic addr_ok;
    logic instr_refuse;
    instr_dec_t wr_dec;

    function automatic logic addr_mapped(input logic [APB_AW-1:0] a);
        case (a)
            ADDR_INSTR, ADDR_BANK, ADDR_STATUS, ADDR_WDT,
            ADDR_MEM_ADDR, ADDR_MEM_DATA, ADDR_IRQ_STAT, ADDR_IRQ_MASK: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : addr_mapped

    // Set-all-ones write happens in quarter four
    assign exec_bank = ir_r.acc_sel ? bank_r : ACCESS_BANK[BANK_BITS-1:0];
    assign exec_addr = {exec_bank, ir_r.faddr};
    assign exec_we = (q_r == Q4) && busy_r && ir_r.set_ones;
    assign sleep_q3 = (q_r == Q3) && busy_r && ir_r.sleep;

    // APB side; core write wins the memory port, so APB waits
    assign apb_access = I_PSEL && I_PENABLE;
    assign addr_ok = addr_mapped(I_PADDR);
    assign wr_dec = decode_instr(I_PWDATA[15:0]);
    assign instr_refuse = pend_r || !(wr_dec.set_ones || wr_dec.sleep);
    // A frozen core cannot take a transfer, so ready drops with the enable
    assign O_PREADY = I_CE && !(exec_we && I_PWRITE && (I_PADDR == ADDR_MEM_DATA));
    assign O_PSLVERR = apb_access && (!addr_ok || (I_PWRITE && (I_PADDR == ADDR_INSTR) && instr_refuse));
    assign apb_fire = apb_access && O_PREADY && !O_PSLVERR;
    assign sw_mem_we = apb_fire && I_PWRITE && (I_PADDR == ADDR_MEM_DATA);

    assign mem_we = exec_we || sw_mem_we;
    assign mem_waddr = exec_we ? exec_addr : mem_addr_r;
    assign mem_wdata = exec_we ? ALL_ONES : I_PWDATA[7:0];

    assign tick_rise = tick_s2_r && !tick_s3_r;
    // Clear in quarter three beats a tick arriving in the same cycle
    assign wdt_to = tick_rise && (&wdt_cnt_r) && (&wdt_post_r) && !sleep_q3;

    sos_data_mem #(
        .AW(MAW),
        .DW(8)
    ) u_mem (
        .i_clk(I_CLK),
        .i_ce(I_CE),
        .i_we(mem_we),
        .i_waddr(mem_waddr),
        .i_wdata(mem_wdata),
        .i_raddr(mem_addr_nxt),
        .o_rdata(mem_rdata)
    );

    always_comb begin
        q_nxt = q_r;
        busy_nxt = busy_r;
        ir_nxt = ir_r;
        pend_nxt = pend_r;
        pend_op_nxt = pend_op_r;
        asleep_nxt = asleep_r;
        flags_nxt = flags_r;
        wdt_cnt_nxt = wdt_cnt_r;
        wdt_post_nxt = wdt_post_r;
        bank_nxt = bank_r;
        mem_addr_nxt = mem_addr_r;
        irq_mask_nxt = irq_mask_r;
        prdata_nxt = prdata_r;
        irq_ev = '0;
        // Quarter sequencer stops while the oscillator is halted
        if (!asleep_r) begin
            case (q_r)
                Q1: q_nxt = Q2;
                Q2: q_nxt = Q3;
                Q3: q_nxt = Q4;
                Q4: q_nxt = Q1;
                default: q_nxt = Q1;
            endcase
        end
        if (!asleep_r && (q_r == Q1)) begin
            busy_nxt = pend_r;
            if (pend_r) begin
                ir_nxt = decode_instr(pend_op_r);
                pend_nxt = 1'b0;
            end
        end
        // Watchdog keeps counting on its own oscillator
        if (tick_rise) begin
            wdt_cnt_nxt = wdt_cnt_r + 8'h01;
            if (&wdt_cnt_r) begin
                wdt_post_nxt = wdt_post_r + 1'b1;
            end
        end
        if (sleep_q3) begin
            flags_nxt.power_down_flag = 1'b0;
            flags_nxt.timeout_flag = 1'b1;
            wdt_cnt_nxt = '0;
            wdt_post_nxt = '0;
        end
        if ((q_r == Q4) && busy_r) begin
            busy_nxt = 1'b0;
            if (ir_r.sleep) begin
                asleep_nxt = 1'b1;
                irq_ev[IRQ_SLEEP] = 1'b1;
            end
            if (ir_r.set_ones) begin
                irq_ev[IRQ_SET_ONES] = 1'b1;
            end
        end
        if (asleep_r && wdt_to) begin
            asleep_nxt = 1'b0;
            flags_nxt.timeout_flag = 1'b0;
            irq_ev[IRQ_WDT_WAKE] = 1'b1;
        end else if (asleep_r && wake_s2_r) begin
            asleep_nxt = 1'b0;
            irq_ev[IRQ_PIN_WAKE] = 1'b1;
        end
        // Register writes
        if (apb_fire && I_PWRITE) begin
            case (I_PADDR)
                ADDR_INSTR: begin
                    pend_nxt = 1'b1;
                    pend_op_nxt = I_PWDATA[15:0];
                end
                ADDR_BANK: bank_nxt = I_PWDATA[BANK_BITS-1:0];
                ADDR_MEM_ADDR: mem_addr_nxt = I_PWDATA[MAW-1:0];
                ADDR_IRQ_MASK: irq_mask_nxt = I_PWDATA[IRQ_W-1:0];
                default: ;
            endcase
        end
        // Sticky status, a new event outranks the write-one clear
        irq_stat_nxt = irq_stat_r | irq_ev;
        if (apb_fire && I_PWRITE && (I_PADDR == ADDR_IRQ_STAT)) begin
            irq_stat_nxt = (irq_stat_r & ~I_PWDATA[IRQ_W-1:0]) | irq_ev;
        end
        // Read data is latched in the setup cycle
        if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
            prdata_nxt = '0;
            case (I_PADDR)
                ADDR_INSTR: prdata_nxt[15:0] = pend_op_r;
                ADDR_BANK: prdata_nxt[BANK_BITS-1:0] = bank_r;
                ADDR_STATUS: begin
                    prdata_nxt[ST_TIMEOUT] = flags_r.timeout_flag;
                    prdata_nxt[ST_PDOWN] = flags_r.power_down_flag;
                    prdata_nxt[ST_ASLEEP] = asleep_r;
                    prdata_nxt[ST_BUSY] = busy_r || pend_r;
                end
                ADDR_WDT: prdata_nxt[8+WDT_POST_BITS-1:0] = {wdt_post_r, wdt_cnt_r};
                ADDR_MEM_ADDR: prdata_nxt[MAW-1:0] = mem_addr_r;
                ADDR_MEM_DATA: prdata_nxt[7:0] = mem_rdata;
                ADDR_IRQ_STAT: prdata_nxt[IRQ_W-1:0] = irq_stat_r;
                ADDR_IRQ_MASK: prdata_nxt[IRQ_W-1:0] = irq_mask_r;
                default: prdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            q_r <= Q1;
            busy_r <= 1'b0;
            ir_r <= '0;
            pend_r <= 1'b0;
            pend_op_r <= '0;
            asleep_r <= 1'b0;
            flags_r.timeout_flag <= TIMEOUT_RST;
            flags_r.power_down_flag <= PDOWN_RST;
            wdt_cnt_r <= '0;
            wdt_post_r <= '0;
            bank_r <= '0;
            mem_addr_r <= '0;
            irq_stat_r <= '0;
            irq_mask_r <= '0;
            prdata_r <= '0;
            tick_s1_r <= 1'b0;
            tick_s2_r <= 1'b0;
            tick_s3_r <= 1'b0;
            wake_s1_r <= 1'b0;
            wake_s2_r <= 1'b0;
        end else if (I_CE) begin
            q_r <= q_nxt;
            busy_r <= busy_nxt;
            ir_r <= ir_nxt;
            pend_r <= pend_nxt;
            pend_op_r <= pend_op_nxt;
            asleep_r <= asleep_nxt;
            flags_r <= flags_nxt;
            wdt_cnt_r <= wdt_cnt_nxt;
            wdt_post_r <= wdt_post_nxt;
            bank_r <= bank_nxt;
            mem_addr_r <= mem_addr_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
            prdata_r <= prdata_nxt;
            tick_s1_r <= I_WDT_TICK;
            tick_s2_r <= tick_s1_r;
            tick_s3_r <= tick_s2_r;
            wake_s1_r <= I_WAKE;
            wake_s2_r <= wake_s1_r;
        end
    end

    assign O_PRDATA = prdata_r;
    assign O_IRQ = |(irq_stat_r & irq_mask_r);
    assign O_SLEEP = asleep_r;
    assign O_OSC_RUN = !asleep_r;
    assign O_TIMEOUT_FLAG = flags_r.timeout_flag;
    assign O_POWER_DOWN_FLAG = flags_r.power_down_flag;

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);

    a_set_all_ones: assert property ((I_CE && (q_r == Q4) && busy_r && ir_r.set_ones) |->
        (mem_we && (mem_wdata == ALL_ONES) && (mem_waddr == exec_addr)))
        else $error("set-all-ones did not write FFh");
    a_access_bank: assert property ((exec_we && !ir_r.acc_sel) |->
        (mem_waddr[MAW-1:8] == ACCESS_BANK[BANK_BITS-1:0]))
        else $error("access bank not used");
    a_bank_select: assert property ((exec_we && ir_r.acc_sel) |->
        ((mem_waddr[MAW-1:8] == bank_r) && (mem_waddr[7:0] == ir_r.faddr)))
        else $error("bank select not used");
    a_set_flags_kept: assert property ((I_CE && exec_we) |=> $stable(flags_r))
        else $error("set-all-ones changed a flag");
    a_sleep_pd_clear: assert property ((I_CE && sleep_q3) |=> !O_POWER_DOWN_FLAG)
        else $error("power-down flag not cleared");
    a_sleep_to_set: assert property ((I_CE && sleep_q3) |=> O_TIMEOUT_FLAG)
        else $error("timeout flag not set");
    a_sleep_wdt_clear: assert property ((I_CE && sleep_q3) |=>
        ((wdt_cnt_r == 8'h00) && (wdt_post_r == '0)))
        else $error("watchdog not cleared");
    a_sleep_entry: assert property ((I_CE && (q_r == Q2) && busy_r && ir_r.sleep)
        ##1 I_CE [*2] |=> (O_SLEEP && !O_OSC_RUN && !O_POWER_DOWN_FLAG))
        else $error("sleep not entered in quarter four");
    a_q2_no_op: assert property ((I_CE && (q_r == Q2) && busy_r && ir_r.sleep) |=>
        ($stable(flags_r) && !asleep_r))
        else $error("quarter two was not idle");
    a_wdt_wake_to: assert property ((I_CE && asleep_r && wdt_to) |=>
        (!O_SLEEP && !O_TIMEOUT_FLAG && irq_stat_r[IRQ_WDT_WAKE]))
        else $error("watchdog wake kept timeout flag");

    a_quarter_q2_q3: assert property ((I_CE && !asleep_r && (q_r == Q2)) |=>
        (q_r == Q3))
        else $error("quarter three did not follow quarter two");
    a_quarter_q3_q4: assert property ((I_CE && !asleep_r && (q_r == Q3)) |=>
        (q_r == Q4))
        else $error("quarter four did not follow quarter three");
    // Halted oscillator means the quarters stand still until a wake
    a_halted_at_q1: assert property (asleep_r |-> (q_r == Q1))
        else $error("quarters moved while asleep");
    a_sleep_persists: assert property ((I_CE && asleep_r && !wdt_to && !wake_s2_r) |=>
        (O_SLEEP && !O_OSC_RUN))
        else $error("left sleep without a wake");
    // Pin wake keeps the timeout flag, only the watchdog clears it
    a_pin_wake_keeps: assert property ((I_CE && asleep_r && wake_s2_r && !wdt_to) |=>
        (!O_SLEEP && $stable(flags_r)))
        else $error("pin wake changed a flag");
    a_flags_awake_stable: assert property ((I_CE && !asleep_r && !sleep_q3) |=>
        $stable(flags_r))
        else $error("flag changed outside sleep");
    a_irq_event_sticks: assert property ((I_CE && (irq_ev != '0)) |=>
        ((irq_stat_r & $past(irq_ev)) == $past(irq_ev)))
        else $error("interrupt event lost");
    a_refused_no_effect: assert property ((I_CE && apb_access && O_PSLVERR) |=>
        ($stable(pend_op_r) && $stable(bank_r) && $stable(irq_mask_r)))
        else $error("refused transfer had an effect");
    a_ce_freeze: assert property (!I_CE |=>
        ($stable(q_r) && $stable(flags_r) && $stable(asleep_r) && $stable(wdt_cnt_r)))
        else $error("state moved with clock enable low");

    c_set_ones_done: cover property (I_CE && exec_we && ir_r.acc_sel);
    c_sleep_entered: cover property (I_CE && (q_r == Q4) && busy_r && ir_r.sleep);
    c_wdt_wake: cover property (I_CE && asleep_r && wdt_to);
    c_pin_wake: cover property (I_CE && asleep_r && wake_s2_r && !wdt_to);
    c_ce_frozen: cover property (!I_CE && !asleep_r);
endmodule : sos_executor

// File: sos_executor_bench.sv
// Self-checking bench for the set-all-ones and sleep executor
`timescale 1ns/10ps
module sos_executor_bench;
    import sos_exec_pkg::*;
    logic clk;
    logic rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata;
    logic [APB_DW-1:0] prdata;
    logic pready;
    logic pslverr;
    logic wdt_tick;
    logic wake;
    logic irq;
    logic asleep;
    logic osc_run;
    logic timeout_flag;
    logic power_down_flag;
    logic ce;
    logic [31:0] rd;
    logic err;
    int err_total;
    int check_count;
    int i;
    int n;
    logic [15:0] ops [4] = '{16'h6800, 16'h68FF, 16'h6900, 16'h69FF};
    logic [11:0] adrs [4] = '{12'h000, 12'h0FF, 12'h300, 12'h3FF};

    // Short postscaler keeps the watchdog timeout within a few thousand cycles
    sos_executor #(.WDT_POST_BITS(1)) uut (
        .I_CLK(clk), .I_RST(rst), .I_CE(ce), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_WDT_TICK(wdt_tick), .I_WAKE(wake), .O_IRQ(irq), .O_SLEEP(asleep), .O_OSC_RUN(osc_run),
        .O_TIMEOUT_FLAG(timeout_flag), .O_POWER_DOWN_FLAG(power_down_flag)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task test_done;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task timed_out(input string name);
        err_total++;
        $display("[ERR] %s expected completion seen timeout", name);
        test_done();
    endtask : timed_out

    // Request held until pready is seen high at a rising edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            k++;
            if (k > 20) timed_out("pready");
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Later output checks then see settled values
        @(negedge clk);
    endtask : apb

    task mem_wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, ADDR_MEM_ADDR, {20'h0, a});
        apb(1'b1, ADDR_MEM_DATA, {24'h0, d});
    endtask : mem_wr

    task mem_rd(input logic [11:0] a);
        apb(1'b1, ADDR_MEM_ADDR, {20'h0, a});
        apb(1'b0, ADDR_MEM_DATA, 32'h0);
    endtask : mem_rd

    task wait_idle;
        rd = 32'hF;
        for (int k = 0; k < 20 && rd[ST_BUSY] !== 1'b0; k++) apb(1'b0, ADDR_STATUS, 32'h0);
        if (rd[ST_BUSY] !== 1'b0) timed_out("busy");
    endtask : wait_idle

    task tick;
        @(posedge clk);
        wdt_tick <= 1'b1;
        repeat (3) @(posedge clk);
        wdt_tick <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : tick

    initial begin
        err_total = 0;
        check_count = 0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        wdt_tick = 1'b0;
        wake = 1'b0;
        ce = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, ADDR_STATUS, 32'h0);
        check("status_reset", rd, 32'h3);
        check("osc_reset", {31'h0, osc_run}, 32'h1);
        $display("test reset done");

        apb(1'b1, ADDR_BANK, 32'h3);
        for (i = 0; i < 4; i++) begin
            mem_wr(adrs[i], 8'h5A);
            mem_wr(adrs[i] ^ 12'h300, 8'h5A);
            apb(1'b1, ADDR_INSTR, {16'h0, ops[i]});
            check("instr_err", {31'h0, err}, 32'h0);
            wait_idle();
            mem_rd(adrs[i]);
            check("target", rd, 32'hFF);
            mem_rd(adrs[i] ^ 12'h300);
            check("other_bank", rd, 32'h5A);
            apb(1'b0, ADDR_STATUS, 32'h0);
            check("flags_kept", rd & 32'h3, 32'h3);
        end
        apb(1'b0, ADDR_INSTR, 32'h0);
        check("instr_readback", rd, 32'h69FF);
        apb(1'b0, ADDR_BANK, 32'h0);
        check("bank_readback", rd, 32'h3);
        $display("test set-all-ones done");

        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        check("irq_stat", rd, 32'h1);
        check("irq_masked", {31'h0, irq}, 32'h0);
        apb(1'b1, ADDR_IRQ_MASK, 32'hF);
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        check("irq_on", {31'h0, irq}, 32'h1);
        apb(1'b1, ADDR_IRQ_STAT, 32'h1);
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        check("irq_cleared", rd, 32'h0);
        check("irq_off", {31'h0, irq}, 32'h0);
        apb(1'b1, ADDR_INSTR, 32'h1234);
        check("bad_opcode", {31'h0, err}, 32'h1);
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped_err", {31'h0, err}, 32'h1);
        check("unmapped_data", rd, 32'h0);
        $display("test interrupts and refusals done");

        repeat (3) tick();
        apb(1'b0, ADDR_WDT, 32'h0);
        check("wdt_running", {31'h0, rd != 32'h0}, 32'h1);
        apb(1'b1, ADDR_INSTR, {16'h0, OP_SLEEP});
        n = 0;
        while (power_down_flag !== 1'b0) begin
            n++;
            if (n > 20) timed_out("power_down_flag");
            @(negedge clk);
        end
        check("asleep_q3", {31'h0, asleep}, 32'h0);
        check("to_set", {31'h0, timeout_flag}, 32'h1);
        @(negedge clk);
        check("asleep_q4", {31'h0, asleep}, 32'h1);
        check("osc_stop", {31'h0, osc_run}, 32'h0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check("status_sleep", rd, 32'h5);
        apb(1'b0, ADDR_WDT, 32'h0);
        check("wdt_cleared", rd, 32'h0);
        @(posedge clk);
        wake <= 1'b1;
        n = 0;
        while (asleep !== 1'b0) begin
            n++;
            if (n > 20) timed_out("pin_wake");
            @(negedge clk);
        end
        @(posedge clk);
        wake <= 1'b0;
        check("to_kept", {31'h0, timeout_flag}, 32'h1);
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        check("irq_pin_wake", rd, 32'hA);
        apb(1'b1, ADDR_IRQ_STAT, 32'hF);
        $display("test sleep and pin wake done");

        apb(1'b1, ADDR_INSTR, {16'h0, OP_SLEEP});
        wait_idle();
        check("asleep_again", {31'h0, asleep}, 32'h1);
        n = 0;
        while (asleep !== 1'b0) begin
            n++;
            if (n > 1100) timed_out("watchdog_wake");
            tick();
        end
        check("to_cleared", {31'h0, timeout_flag}, 32'h0);
        check("power_down_low", {31'h0, power_down_flag}, 32'h0);
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        check("irq_wdt_wake", rd, 32'h6);
        $display("test watchdog wake done");

        // Ticks while the enable is low must be lost, the counter frozen
        @(posedge clk);
        ce <= 1'b0;
        repeat (2) tick();
        ce <= 1'b1;
        apb(1'b0, ADDR_WDT, 32'h0);
        check("wdt_frozen", rd, 32'h0);
        tick();
        apb(1'b0, ADDR_WDT, 32'h0);
        check("wdt_counts", rd, 32'h1);
        $display("test clock enable done");
        test_done();
    end
endmodule : sos_executor_bench
